/* design/bzs_codec.sv */
// Zero-suppression line encoder and decoder with register file.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module bzs_codec (
    input  wire logic                   sys_clk,
    input  wire logic                   rstn,
    input  wire logic                   clk_en,
    input  wire logic                   datapath_reset_n,
    input  wire logic                   e3_mode,
    input  wire logic                   tx_data,
    input  wire logic                   tx_data_valid,
    input  wire logic                   manual_insert_input,
    output logic                        tx_pos,
    output logic                        tx_neg,
    output logic                        tx_line_valid,
    input  wire logic                   rx_pos,
    input  wire logic                   rx_neg,
    input  wire logic                   rx_line_valid,
    input  wire logic                   rx_los,
    output logic                        rx_data,
    output logic                        rx_data_valid,
    input  wire logic [7:0]             reg_addr,
    input  wire logic [15:0]            reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic [15:0]                 reg_rdata
);
    import bzs_pkg::*;

    typedef struct packed {
        logic [15:0]      tx_ctrl;
        logic [15:0]      rx_ctrl;
        logic [5:0]       latch;
        logic [5:0]       ie;
        logic [15:0]      vcnt;
        logic [15:0]      zcnt;
        logic [15:0]      rdata;
        logic             man_s1;
        logic             man_s2;
        logic             los_s1;
        logic             los_s2;
        logic             dpr_s1;
        logic             dpr_s2;
        logic             trig_prev;
        logic             pend_bpv;
        logic             pend_exz;
        bzs_tx_state_type tx_st;
        logic [1:0]       tx_left;
        logic [3:0]       tx_pipe;
        logic             tx_last_neg;
        logic             tx_odd;
        logic             tx_pos;
        logic             tx_neg;
        logic             tx_ovalid;
        logic [3:0]       rx_p;
        logic [3:0]       rx_n;
        logic             rx_last_neg;
        logic             rx_any;
        logic [2:0]       rx_zrun;
        logic             dec_seen;
        logic             dec_pol;
        logic             det_seen;
        logic             det_pol;
        logic             bpv_have;
        logic             bpv_pol;
        logic             los_prev;
        logic             rx_data;
        logic             rx_dvalid;
    } bzs_state_type;

    localparam bzs_state_type ST_RST = '0;

    bzs_state_type q;
    bzs_state_type d;

    logic       [1:0] run_left;
    logic             tx_run;
    logic             rx_pulse;
    logic             rx_viol;
    logic             zero_pre;
    logic             dec_sig;
    logic             det_sig;
    logic             bpv_ev;
    logic             cv_ev;
    logic             cnt_ev;
    logic             zrun_ev;
    logic             los_live;
    logic             trig;
    logic             rd_vcnt;
    logic             rd_zcnt;

    // Run length and trigger source depend on mode and control bits.
    assign run_left = e3_mode ? HD_LEFT : B3_LEFT;
    // source select: manual input or register bit.
    assign trig     = q.tx_ctrl[TX_SRC_SEL] ? q.man_s2 : q.tx_ctrl[TX_SEI];
    // substitution: only when the disable bit is clear.
    assign tx_run   = ~q.tx_ctrl[TX_SUB_DIS] &
                      (e3_mode ? ~|q.tx_pipe : ~|q.tx_pipe[3:1]);

    // Receive violation: a pulse of the same polarity as the last one.
    assign rx_pulse = rx_pos | rx_neg;
    assign rx_viol  = rx_line_valid & rx_pulse & q.rx_any &
                      (rx_neg == q.rx_last_neg);
    assign zero_pre = e3_mode ? ~|{q.rx_p[1:0], q.rx_n[1:0]}
                              : ~(q.rx_p[0] | q.rx_n[0]);
    // decode codeword, polarity check after the first.
    assign dec_sig  = rx_viol & zero_pre &
                      (~q.dec_seen | ~q.rx_ctrl[RX_DEC_FMT] |
                       (rx_neg != q.dec_pol));
    assign det_sig  = rx_viol & zero_pre &
                      (~q.det_seen | ~q.rx_ctrl[RX_DET_FMT] |
                       (rx_neg != q.det_pol));
    assign bpv_ev   = rx_viol & ~det_sig;
    // code violation: two violations of the same polarity.
    assign cv_ev    = bpv_ev & q.bpv_have & (rx_neg == q.bpv_pol);
    // counted event, code violations only in HDB3 mode with RX_CV_EN set.
    assign cnt_ev   = (e3_mode & q.rx_ctrl[RX_CV_EN]) ? cv_ev : bpv_ev;
    assign zrun_ev  = rx_line_valid & ~rx_pulse &
                      (q.rx_zrun == {1'b0, run_left});
    // loss of signal is forced clear while decoding is off.
    assign los_live = q.los_s2 & ~q.rx_ctrl[RX_SUB_DIS];
    assign rd_vcnt  = reg_rd & (reg_addr == A_VIOL_CNT);
    assign rd_zcnt  = reg_rd & (reg_addr == A_ZERO_CNT);

    // Next-state logic for the whole block.
    always_comb begin
        logic [3:0]  pp;
        logic [3:0]  nn;
        logic [15:0] vb;
        logic [15:0] zb;
        logic [5:0]  lset;
        logic [5:0]  lclr;
        logic [15:0] stat;
        pp   = '0;
        nn   = '0;
        vb   = '0;
        zb   = '0;
        lset = '0;
        lclr = '0;
        stat = '0;
        d    = q;
        // Manual insert, loss-of-signal and datapath reset pins pass two flops before use.
        d.man_s1 = manual_insert_input;
        d.man_s2 = q.man_s1;
        d.los_s1 = rx_los;
        d.los_s2 = q.los_s1;
        d.dpr_s1 = datapath_reset_n;
        d.dpr_s2 = q.dpr_s1;

        // Register writes; reserved bits stay zero.
        if (reg_wr) begin
            case (reg_addr)
                A_TX_CTRL:  d.tx_ctrl = reg_wdata & TX_MASK;
                A_RX_CTRL:  d.rx_ctrl = reg_wdata & RX_MASK;
                A_RX_IE:    d.ie = reg_wdata[5:0] & IE_MASK;
                A_RX_LATCH: lclr = reg_wdata[5:0];
                default: ;
            endcase
        end

        // Transmit sequencer, one line symbol per valid data bit.
        d.tx_ovalid = 1'b0;
        if (tx_data_valid) begin
            d.tx_ovalid = 1'b1;
            d.tx_pos    = 1'b0;
            d.tx_neg    = 1'b0;
            d.tx_pipe   = {q.tx_pipe[2:0], tx_data};
            case (q.tx_st)
                TX_DATA: begin
                    // zero-run error taken at any position.
                    if (q.pend_exz) begin
                        d.pend_exz = 1'b0;
                        d.tx_st    = TX_ZERO;
                        d.tx_left  = run_left;
                    end else if (tx_run) begin
                        d.tx_st   = TX_SUB;
                        d.tx_left = run_left;
                        // Even pulse count since last V needs a B pulse.
                        if (!q.tx_odd) begin
                            d.tx_pos      = q.tx_last_neg;
                            d.tx_neg      = ~q.tx_last_neg;
                            d.tx_last_neg = ~q.tx_last_neg;
                        end
                    end else if (q.tx_pipe[3]) begin
                        // violation applied on the next mark.
                        if (q.pend_bpv) begin
                            d.pend_bpv = 1'b0;
                            d.tx_pos   = ~q.tx_last_neg;
                            d.tx_neg   = q.tx_last_neg;
                        end else begin
                            d.tx_pos      = q.tx_last_neg;
                            d.tx_neg      = ~q.tx_last_neg;
                            d.tx_last_neg = ~q.tx_last_neg;
                            d.tx_odd      = ~q.tx_odd;
                        end
                    end
                end
                TX_SUB: begin
                    // The last symbol of a codeword repeats polarity.
                    if (q.tx_left == 2'h1) begin
                        d.tx_pos = ~q.tx_last_neg;
                        d.tx_neg = q.tx_last_neg;
                        d.tx_odd = 1'b0;
                        d.tx_st  = TX_DATA;
                    end
                    d.tx_left = q.tx_left - 2'h1;
                end
                TX_ZERO: begin
                    // Data bits under a forced zero run are dropped.
                    if (q.tx_left == 2'h1) begin
                        d.tx_st = TX_DATA;
                    end
                    d.tx_left = q.tx_left - 2'h1;
                end
                default: d.tx_st = TX_DATA;
            endcase
        end

        // edge arms one pending error per enabled type.
        d.trig_prev = trig;
        if (trig && !q.trig_prev) begin
            if (q.tx_ctrl[TX_VIOL_EN]) begin
                d.pend_bpv = 1'b1;
            end
            if (q.tx_ctrl[TX_ZRUN_EN]) begin
                d.pend_exz = 1'b1;
            end
        end

        // Receive path, delayed four symbols so codewords can be erased.
        d.rx_dvalid = 1'b0;
        if (rx_line_valid) begin
            pp = {q.rx_p[2:0], rx_pos};
            nn = {q.rx_n[2:0], rx_neg};
            // codewords removed only while decoding is enabled.
            if (dec_sig && !q.rx_ctrl[RX_SUB_DIS]) begin
                pp = pp & (e3_mode ? 4'h0 : 4'h8);
                nn = nn & (e3_mode ? 4'h0 : 4'h8);
            end
            d.rx_p      = pp;
            d.rx_n      = nn;
            d.rx_data   = q.rx_p[3] | q.rx_n[3];
            d.rx_dvalid = 1'b1;
            if (rx_pulse) begin
                d.rx_last_neg = rx_neg;
                d.rx_any      = 1'b1;
                d.rx_zrun     = 3'h0;
            end else if (q.rx_zrun != 3'h7) begin
                d.rx_zrun = q.rx_zrun + 3'h1;
            end
            if (dec_sig) begin
                d.dec_seen = 1'b1;
                d.dec_pol  = rx_neg;
            end
            if (det_sig) begin
                d.det_seen = 1'b1;
                d.det_pol  = rx_neg;
            end
            if (bpv_ev) begin
                d.bpv_have = 1'b1;
                d.bpv_pol  = rx_neg;
            end
        end

        // saturating counters; a read clears, an event still counts.
        vb = rd_vcnt ? 16'h0000 : q.vcnt;
        if (cnt_ev && vb != CNT_MAX) begin
            vb = vb + 16'h0001;
        end
        zb = rd_zcnt ? 16'h0000 : q.zcnt;
        if (zrun_ev && zb != CNT_MAX) begin
            zb = zb + 16'h0001;
        end
        d.vcnt = vb;
        d.zcnt = zb;

        // latched events; a new event wins over a clear.
        lset[ST_LOS]     = los_live != q.los_prev;
        lset[ST_VIOL_NZ] = ~|q.vcnt & |vb;
        lset[ST_VIOL]    = cnt_ev;
        lset[ST_ZRUN_NZ] = ~|q.zcnt & |zb;
        lset[ST_ZRUN]    = zrun_ev;
        lset[ST_SIG]     = det_sig;
        d.latch    = (q.latch & ~lclr) | lset;
        d.los_prev = los_live;

        stat[ST_LOS]     = los_live;
        stat[ST_VIOL_NZ] = |q.vcnt;
        stat[ST_ZRUN_NZ] = |q.zcnt;

        // Read data stands only in the cycle after the strobe.
        d.rdata = 16'h0000;
        if (reg_rd) begin
            case (reg_addr)
                A_TX_CTRL:  d.rdata = q.tx_ctrl;
                A_RX_CTRL:  d.rdata = q.rx_ctrl;
                A_RX_STAT:  d.rdata = stat;
                A_RX_LATCH: d.rdata = {10'h000, q.latch};
                A_RX_IE:    d.rdata = {10'h000, q.ie};
                A_VIOL_CNT: d.rdata = q.vcnt;
                A_ZERO_CNT: d.rdata = q.zcnt;
                default:    d.rdata = 16'h0000;
            endcase
        end

        // datapath reset restarts the first-signature rule.
        if (!q.dpr_s2) begin
            d.tx_pipe  = '0;
            d.tx_st    = TX_DATA;
            d.tx_left  = 2'h0;
            d.tx_odd   = 1'b0;
            d.rx_p     = '0;
            d.rx_n     = '0;
            d.rx_any   = 1'b0;
            d.rx_zrun  = 3'h0;
            d.dec_seen = 1'b0;
            d.det_seen = 1'b0;
            d.bpv_have = 1'b0;
        end
    end

    // state register; everything clears on reset.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            q <= ST_RST;
        end else if (clk_en) begin
            q <= d;
        end
    end

    assign tx_pos        = q.tx_pos;
    assign tx_neg        = q.tx_neg;
    assign tx_line_valid = q.tx_ovalid;
    assign rx_data       = q.rx_data;
    assign rx_data_valid = q.rx_dvalid;
    assign reg_rdata     = q.rdata;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    sequence s_reg_rise;
        clk_en && !q.tx_ctrl[TX_SRC_SEL] && q.tx_ctrl[TX_SEI] &&
        !q.trig_prev;
    endsequence

    sequence s_man_rise;
        clk_en && q.tx_ctrl[TX_SRC_SEL] && q.man_s2 && !q.trig_prev;
    endsequence

    sequence s_mark_slot;
        clk_en && tx_data_valid && q.tx_st == TX_DATA &&
        !q.pend_exz && !tx_run && q.tx_pipe[3];
    endsequence

    chk_sub_disable: assert property (
        q.tx_ctrl[TX_SUB_DIS] && q.tx_st == TX_DATA |=>
        q.tx_st != TX_SUB)
        else $error("substitution started while disabled");
    chk_zrun_gate: assert property (
        !q.tx_ctrl[TX_ZRUN_EN] && !q.pend_exz |=> !q.pend_exz)
        else $error("zero-run error armed while disabled");
    chk_viol_gate: assert property (
        !q.tx_ctrl[TX_VIOL_EN] && !q.pend_bpv |=> !q.pend_bpv)
        else $error("violation error armed while disabled");
    chk_reg_trigger: assert property (
        s_reg_rise ##0 q.tx_ctrl[TX_VIOL_EN] |=> q.pend_bpv)
        else $error("register edge did not arm an error");
    chk_man_trigger: assert property (
        s_man_rise ##0 q.tx_ctrl[TX_ZRUN_EN] |=> q.pend_exz)
        else $error("manual edge did not arm an error");
    chk_pend_apply: assert property (
        s_mark_slot ##0 q.pend_bpv && !(trig && !q.trig_prev) |=>
        !q.pend_bpv && tx_line_valid &&
        tx_neg == $past(q.tx_last_neg) && tx_pos != $past(q.tx_last_neg))
        else $error("pending violation not applied");
    chk_pend_hold: assert property (
        q.pend_bpv && !tx_data_valid |=> q.pend_bpv)
        else $error("pending error lost without opportunity");
    chk_count_stat: assert property (
        clk_en && reg_rd && reg_addr == A_RX_STAT |=>
        reg_rdata[ST_VIOL_NZ] == |$past(q.vcnt) &&
        reg_rdata[ST_ZRUN_NZ] == |$past(q.zcnt))
        else $error("count status bit wrong");
    chk_los_clear: assert property (
        clk_en && reg_rd && reg_addr == A_RX_STAT &&
        q.rx_ctrl[RX_SUB_DIS] |=>
        !reg_rdata[ST_LOS])
        else $error("loss of signal shown while decoding off");
    chk_count_sat: assert property (
        clk_en && q.vcnt == CNT_MAX && !rd_vcnt |=> q.vcnt == CNT_MAX)
        else $error("violation counter wrapped");
    chk_count_step: assert property (
        clk_en && cnt_ev && !rd_vcnt && q.vcnt != CNT_MAX |=>
        q.vcnt == $past(q.vcnt) + 16'h0001)
        else $error("violation counter did not step by one");
    chk_viol_latch: assert property (
        clk_en && cnt_ev |=> q.latch[ST_VIOL])
        else $error("violation latch not set");
    chk_ctrl_reset: assert property (
        $rose(rstn) |-> q.tx_ctrl == CTRL_RST && q.rx_ctrl == CTRL_RST)
        else $error("control registers not cleared");
endmodule
`default_nettype wire

/* design/bzs_pkg.sv */
// Constants and types shared by the zero-suppression line codec.
package bzs_pkg;
    // Register byte offsets.
    localparam logic [7:0]  A_TX_CTRL  = 8'h8c;
    localparam logic [7:0]  A_RX_CTRL  = 8'h90;
    localparam logic [7:0]  A_RX_STAT  = 8'h94;
    localparam logic [7:0]  A_RX_LATCH = 8'h96;
    localparam logic [7:0]  A_RX_IE    = 8'h98;
    localparam logic [7:0]  A_VIOL_CNT = 8'h9c;
    localparam logic [7:0]  A_ZERO_CNT = 8'h9e;
    // Writable bits, reset values and counter limit.
    localparam logic [15:0] TX_MASK    = 16'h001f;
    localparam logic [15:0] RX_MASK    = 16'h000f;
    localparam logic [5:0]  IE_MASK    = 6'h3f;
    localparam logic [15:0] CTRL_RST   = 16'h0000;
    localparam logic [15:0] CNT_MAX    = 16'hffff;
    // Transmit control fields.
    localparam int TX_SRC_SEL   = 0;
    localparam int TX_SEI       = 1;
    localparam int TX_VIOL_EN   = 2;
    localparam int TX_ZRUN_EN   = 3;
    localparam int TX_SUB_DIS   = 4;
    // Receive control fields.
    localparam int RX_SUB_DIS   = 0;
    localparam int RX_DEC_FMT   = 1;
    localparam int RX_DET_FMT   = 2;
    localparam int RX_CV_EN     = 3;
    // Status and latched status fields.
    localparam int ST_LOS       = 0;
    localparam int ST_VIOL_NZ   = 1;
    localparam int ST_VIOL      = 2;
    localparam int ST_ZRUN_NZ   = 3;
    localparam int ST_ZRUN      = 4;
    localparam int ST_SIG       = 5;
    // Symbols left after the first one of a substituted run.
    localparam logic [1:0]  B3_LEFT    = 2'h2;
    localparam logic [1:0]  HD_LEFT    = 2'h3;
    // Transmit sequencer states.
    typedef enum logic [1:0] {
        TX_DATA = 2'b00,
        TX_SUB  = 2'b01,
        TX_ZERO = 2'b10
    } bzs_tx_state_type;
endpackage

/* tb/bzs_codec_tb.sv */
// Self-checking testbench for the zero-suppression line codec.
`timescale 1ns/10ps
`default_nettype none
module bzs_codec_tb;
    import bzs_pkg::*;
    typedef struct {int hd, cv, en, trig, ev, ez;} bzs_tb_case_type;
    logic        sys_clk, rstn, clk_en, datapath_reset_n, e3_mode;
    logic        tx_data, tx_data_valid, manual_insert_input;
    logic        tx_pos, tx_neg, tx_line_valid, rx_los;
    logic        rx_pos, rx_neg, rx_line_valid, rx_data, rx_data_valid;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, rv, v;
    logic        reg_wr, reg_rd;
    logic        sent_q[$];
    int          failures, tests_run, rx_cnt, zrun, zmax;
    bzs_tb_case_type cases[9] = '{'{0,0,4,0,1,0}, '{0,0,4,1,0,0},
        '{0,1,4,2,1,0}, '{1,0,4,0,1,0}, '{1,1,4,0,0,0}, '{0,0,0,0,0,0},
        '{1,0,8,3,0,1}, '{0,0,8,0,0,1}, '{1,1,4,4,1,0}};

    bzs_codec i_bzs_codec (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en),
        .datapath_reset_n(datapath_reset_n), .e3_mode(e3_mode),
        .tx_data(tx_data), .tx_data_valid(tx_data_valid),
        .manual_insert_input(manual_insert_input), .tx_pos(tx_pos),
        .tx_neg(tx_neg), .tx_line_valid(tx_line_valid), .rx_pos(rx_pos),
        .rx_neg(rx_neg), .rx_line_valid(rx_line_valid), .rx_los(rx_los),
        .rx_data(rx_data), .rx_data_valid(rx_data_valid),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    bzs_line_model i_bzs_line_model (.sys_clk(sys_clk), .rstn(rstn),
        .clk_en(clk_en), .tx_pos(tx_pos), .tx_neg(tx_neg),
        .tx_line_valid(tx_line_valid), .rx_pos(rx_pos), .rx_neg(rx_neg),
        .rx_line_valid(rx_line_valid));

    // Free-running system clock.
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        {clk_en, reg_wr} <= 2'h3;
        {reg_addr, reg_wdata} <= {a, d};
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        {clk_en, reg_rd} <= 2'h3;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // One data bit, sometimes followed by a frozen clock-enable cycle.
    task automatic send(input logic b);
        @(posedge sys_clk);
        {clk_en, tx_data, tx_data_valid} <= {1'b1, b, 1'b1};
        @(posedge sys_clk);
        tx_data_valid <= 1'b0;
        clk_en <= ($urandom_range(3) != 0);
        sent_q.push_back(b);
    endtask

    task automatic dp_reset();
        @(posedge sys_clk);
        {clk_en, datapath_reset_n} <= 2'h2;
        repeat (3) @(posedge sys_clk);
        datapath_reset_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Decoded bits trail the sent bits by eight symbol slots.
    always @(posedge sys_clk) begin
        if (rx_data_valid && clk_en && rx_cnt >= 0) begin
            if (rx_cnt >= 8)
                chk({15'h0, rx_data}, {15'h0, sent_q[rx_cnt-8]});
            rx_cnt++;
        end
    end

    // Longest zero run seen on the transmit line.
    always @(posedge sys_clk) begin
        if (tx_line_valid && clk_en) begin
            zrun = (tx_pos || tx_neg) ? 0 : zrun + 1;
            if (zrun > zmax)
                zmax = zrun;
        end
    end

    // Random loopback stream in one mode; substitution bounds zero runs.
    task automatic stream(input logic hd, input logic nosub);
        @(posedge sys_clk);
        e3_mode <= hd;
        wr(A_TX_CTRL, 16'(nosub) << TX_SUB_DIS);
        wr(A_RX_CTRL, 16'h4 | 16'(nosub) | 16'($urandom_range(1)) << 1);
        dp_reset();
        sent_q.delete();
        {rx_cnt, zrun, zmax} = {32'd0, 32'd0, 32'd0};
        repeat (60) send($urandom_range(3) == 0);
        repeat (6) @(posedge sys_clk);
        rx_cnt = -1;
        chk({15'h0, zmax >= (hd ? 4 : 3)}, {15'h0, nosub});
    endtask

    // Zero, one or two triggered insertions, then counters, status and the latched violation flag.
    task automatic run_case(input bzs_tb_case_type c);
        logic [15:0] en;
        en = 16'(c.en);
        @(posedge sys_clk);
        e3_mode <= c.hd[0];
        wr(A_RX_CTRL, 16'h4 | 16'(c.cv) << RX_CV_EN);
        dp_reset();
        repeat (16) send(1'b1);
        repeat (6) @(posedge sys_clk);
        rd(A_VIOL_CNT, rv);
        rd(A_ZERO_CNT, rv);
        wr(A_RX_LATCH, 16'h003f);
        case (c.trig)
            0: wr(A_TX_CTRL, en);
            1: wr(A_TX_CTRL, en | 16'h2);
            2: repeat (2) begin
                wr(A_TX_CTRL, en);
                wr(A_TX_CTRL, en | 16'h2);
            end
            4: begin
                // two violations, two plain marks apart, match.
                wr(A_TX_CTRL, en);
                wr(A_TX_CTRL, en | 16'h2);
                repeat (3) send(1'b1);
                wr(A_TX_CTRL, en);
            end
            default: begin
                wr(A_TX_CTRL, en);
                wr(A_TX_CTRL, en | 16'h1);
                manual_insert_input <= 1'b1;
                repeat (4) @(posedge sys_clk);
                manual_insert_input <= 1'b0;
                repeat (4) @(posedge sys_clk);
            end
        endcase
        if (c.trig != 3)
            wr(A_TX_CTRL, en | 16'h2);
        repeat (16) send(1'b1);
        repeat (6) @(posedge sys_clk);
        rd(A_RX_STAT, rv);
        chk({15'h0, rv[ST_VIOL_NZ]}, 16'(c.ev));
        chk({15'h0, rv[ST_ZRUN_NZ]}, 16'(c.ez));
        rd(A_RX_LATCH, rv);
        chk({15'h0, rv[ST_VIOL]}, 16'(c.ev));
        rd(A_VIOL_CNT, rv);
        chk(rv, 16'(c.ev));
        rd(A_ZERO_CNT, rv);
        chk(rv, 16'(c.ez));
        rd(A_RX_STAT, rv);
        chk(rv & 16'h000a, 16'h0);
    endtask

    // Main sequence.
    initial begin
        {rstn, clk_en, datapath_reset_n, e3_mode} = 4'h6;
        {tx_data, tx_data_valid, manual_insert_input, rx_los} = 4'h0;
        {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        {failures, tests_run, rx_cnt, zrun, zmax} = {32'd0, 32'd0, -32'd1,
            32'd0, 32'd0};
        void'($urandom(42669));
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        rd(A_TX_CTRL, rv);
        chk(rv, CTRL_RST);
        rd(A_RX_CTRL, rv);
        chk(rv, CTRL_RST);
        repeat (4) begin
            v = 16'($urandom);
            wr(A_RX_CTRL, v);
            rd(A_RX_CTRL, rv);
            chk(rv, v & RX_MASK);
            wr(A_RX_IE, v);
            rd(A_RX_IE, rv);
            chk(rv, v & {10'h0, IE_MASK});
            wr(A_TX_CTRL, v & 16'h0011);
            rd(A_TX_CTRL, rv);
            chk(rv, v & 16'h0011);
            wr(8'h92, v);
            rd(8'h92, rv);
            chk(rv, 16'h0);
        end
        wr(A_TX_CTRL, 16'h0);
        wr(A_RX_CTRL, 16'h0);
        rx_los <= 1'b1;
        repeat (6) @(posedge sys_clk);
        rd(A_RX_STAT, rv);
        chk({15'h0, rv[ST_LOS]}, 16'h1);
        wr(A_RX_CTRL, 16'h1);
        repeat (4) @(posedge sys_clk);
        rd(A_RX_STAT, rv);
        chk({15'h0, rv[ST_LOS]}, 16'h0);
        rx_los <= 1'b0;
        for (int m = 0; m < 4; m++)
            stream(m[1], m[0]);
        foreach (cases[i])
            run_case(cases[i]);
        wrap_up();
    end

    // Watchdog against a hung handshake.
    initial begin
        repeat (30000) @(posedge sys_clk);
        failures++;
        wrap_up();
    end
endmodule
`default_nettype wire

/* tb/bzs_line_model.sv */
// Line model that carries transmitted symbols back to the receiver.
`timescale 1ns/10ps
`default_nettype none
module bzs_line_model (
    input  wire logic sys_clk,
    input  wire logic rstn,
    input  wire logic clk_en,
    input  wire logic tx_pos,
    input  wire logic tx_neg,
    input  wire logic tx_line_valid,
    output logic      rx_pos,
    output logic      rx_neg,
    output logic      rx_line_valid
);
    logic pos_ff, neg_ff, vld_ff, junk_ff;
    // A symbol crosses the cable in one enabled clock.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            {pos_ff, neg_ff, vld_ff, junk_ff} <= 4'h0;
        end else begin
            junk_ff <= ~junk_ff;
            if (clk_en) begin
                {pos_ff, neg_ff, vld_ff} <= {tx_pos, tx_neg, tx_line_valid};
            end
        end
    end
    // Between symbols the mark line toggles, so a stale mark is never data.
    assign rx_pos        = vld_ff ? pos_ff : junk_ff;
    assign rx_neg        = vld_ff & neg_ff;
    assign rx_line_valid = vld_ff;
endmodule
`default_nettype wire
